// ### core/rtcakl_pkg.sv
// Constants for the real-time clock alarm, calibration and key-lock slice.
// Assumes a single 200 MHz system clock and an 8-bit special function register port.
package rtcakl_pkg;
    // ----------------------------------------------------------------
    // Clock and register map
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 200_000_000;
    localparam logic [7:0] ADDR_ALARM_INTERVAL = 8'hA6;
    localparam logic [7:0] ADDR_WRITE_KEY = 8'hC1;
    localparam logic [7:0] ADDR_NOM_COMP = 8'hF6;
    localparam logic [7:0] ADDR_TEMP_COMP = 8'hF7;
    localparam logic [7:0] ADDR_PIN_CFG = 8'hFF;
    localparam logic [7:0] ADDR_HUNDREDTHS = 8'hA2;
    localparam logic [7:0] ADDR_HOURS = 8'hA5;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'hC5;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] KEY_POWER = 8'hA7;
    localparam logic [7:0] KEY_TIMEKEEP = 8'hEA;
    // ----------------------------------------------------------------
    // Pin configuration fields
    // ----------------------------------------------------------------
    localparam int CAL_EN_BIT = 7;
    localparam int CAL_FREQUENCY_SELECT_HI = 6;
    localparam int CAL_FREQUENCY_SELECT_LO = 5;
    localparam int IRQ1_HI = 3;
    localparam int IRQ1_MID = 2;
    localparam int IRQ1_LO = 1;
    localparam int IRQ0_BIT = 0;
    localparam logic [7:0] PIN_CFG_MASK = 8'hEF;
    typedef enum logic [1:0] {
        CAL_FREQUENCY_SELECT_1HZ = 2'b00,
        CAL_FREQUENCY_SELECT_512HZ = 2'b01,
        CAL_FREQUENCY_SELECT_500HZ = 2'b10,
        CAL_FREQUENCY_SELECT_16KHZ = 2'b11
    } rtcakl_cal_frequency_select_t;
    // ----------------------------------------------------------------
    // Calibration output and compensation timing
    // ----------------------------------------------------------------
    localparam int CAL_HZ_1 = 1;
    localparam int CAL_HZ_512 = 512;
    localparam int CAL_HZ_500 = 500;
    localparam int CAL_HZ_16K = 16384;
    localparam int CAL_HALF_1HZ = CLK_HZ / (2 * CAL_HZ_1);
    localparam int CAL_HALF_512HZ = CLK_HZ / (2 * CAL_HZ_512);
    localparam int CAL_HALF_500HZ = CLK_HZ / (2 * CAL_HZ_500);
    localparam int CAL_HALF_16KHZ = CLK_HZ / (2 * CAL_HZ_16K);
    localparam int COMP_PPM_PER_LSB = 2;
    localparam int COMP_LIMIT_PPM = 248;
    localparam logic signed [8:0] COMP_MAX = 9'(COMP_LIMIT_PPM / COMP_PPM_PER_LSB);
    localparam logic signed [8:0] COMP_MIN = -COMP_MAX;
endpackage

// ### core/rtcakl_core.sv
// Alarm interval comparator, crystal compensation holding registers, calibration
// output and key-locked register writes. Assumes the interval time base arrives as
// a one-cycle tick and warm resets arrive as a synchronous high level.
//
// How it works
// RL1 - Alarm when interval count reaches programmed value.
// RL2 - Interval counter is eight bits wide.
// RL3 - Eight-bit nominal compensation register kept.
// RL4 - Eight-bit temperature compensation register kept.
// RL5 - Compensation survives warm reset, cleared power-on.
// RL6 - Calibration enable drives selected frequency out.
// RL7 - Frequency select picks one of four rates.
// RL8 - Pin configuration fields decode external pin functions.
// RL9 - Power control write needs key A7.
// RL10 - Pin config and counters need key EA.
// RL11 - Repeat or hold counter after alarm.
// RL12 - Compensation sum clamped to 248 ppm.
// RL13 - Software clears key after protected write.
// RL14 - Unkeyed protected writes are ignored.
// RL15 - Reset clears registers, disables calibration output.
`timescale 1ns/100ps
`default_nettype none
module rtcakl_core #(
    parameter int CAL_HALF_1HZ = rtcakl_pkg::CAL_HALF_1HZ,
    parameter int CAL_HALF_512HZ = rtcakl_pkg::CAL_HALF_512HZ,
    parameter int CAL_HALF_500HZ = rtcakl_pkg::CAL_HALF_500HZ,
    parameter int CAL_HALF_16KHZ = rtcakl_pkg::CAL_HALF_16KHZ
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic warm_reset,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic interval_tick,
    input wire logic interval_enable,
    input wire logic single_interval_stop,
    input wire logic alarm_flag_clear,
    output logic [7:0] sfr_rdata_q,
    output logic alarm_flag_q,
    output logic rtc_irq_pulse_q,
    output logic [7:0] interval_count_q,
    output logic [7:0] comp_total_q,
    output logic cal_out_q,
    output logic cal_out_enable_q,
    output logic ext_irq0_pin_enable_q,
    output logic ext_irq1_gpio_q,
    output logic battery_switch_control_q,
    output logic ext_irq1_input_en_q,
    output logic power_control_wr_q,
    output logic timekeep_wr_q,
    output logic [7:0] prot_addr_q,
    output logic [7:0] prot_wdata_q
);
    // ----------------------------------------------------------------
    // Register file and key lock
    // ----------------------------------------------------------------
    logic [7:0] alarm_interval_q, alarm_interval_d;
    logic [7:0] write_key_q, write_key_d;
    logic [7:0] pin_cfg_q, pin_cfg_d;
    logic [7:0] rdata_d, prot_addr_d, prot_wdata_d;
    logic [7:0] nom_comp_q, nom_comp_d, temp_comp_q, temp_comp_d;
    logic tk_addr, pwr_wr_d, tk_wr_d;
    assign tk_addr = sfr_addr >= rtcakl_pkg::ADDR_HUNDREDTHS && sfr_addr <= rtcakl_pkg::ADDR_HOURS;
    always_comb begin
        alarm_interval_d = alarm_interval_q;
        write_key_d = write_key_q;
        pin_cfg_d = pin_cfg_q;
        rdata_d = sfr_rdata_q;
        pwr_wr_d = 1'b0;
        tk_wr_d = 1'b0;
        prot_addr_d = prot_addr_q;
        prot_wdata_d = prot_wdata_q;
        if (sfr_wr) begin
            unique case (sfr_addr)
                rtcakl_pkg::ADDR_ALARM_INTERVAL: alarm_interval_d = sfr_wdata;
                rtcakl_pkg::ADDR_WRITE_KEY: write_key_d = sfr_wdata;
                rtcakl_pkg::ADDR_PIN_CFG: begin
                    if (write_key_q == rtcakl_pkg::KEY_TIMEKEEP) begin
                        pin_cfg_d = sfr_wdata & rtcakl_pkg::PIN_CFG_MASK; // [RL10] [RL14]
                    end
                end
                rtcakl_pkg::ADDR_POWER_CONTROL: begin
                    pwr_wr_d = (write_key_q == rtcakl_pkg::KEY_POWER); // [RL9] [RL14]
                end
                default: begin
                    tk_wr_d = tk_addr && (write_key_q == rtcakl_pkg::KEY_TIMEKEEP); // [RL10]
                end
            endcase
            if (pwr_wr_d || tk_wr_d) begin
                prot_addr_d = sfr_addr;
                prot_wdata_d = sfr_wdata;
            end
        end
        if (sfr_rd) begin
            unique case (sfr_addr)
                rtcakl_pkg::ADDR_ALARM_INTERVAL: rdata_d = alarm_interval_q;
                rtcakl_pkg::ADDR_WRITE_KEY: rdata_d = write_key_q;
                rtcakl_pkg::ADDR_NOM_COMP: rdata_d = nom_comp_q;
                rtcakl_pkg::ADDR_TEMP_COMP: rdata_d = temp_comp_q;
                rtcakl_pkg::ADDR_PIN_CFG: rdata_d = pin_cfg_q;
                default: rdata_d = rtcakl_pkg::BYTE_ZERO;
            endcase
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alarm_interval_q <= rtcakl_pkg::BYTE_ZERO; // [RL15]
            write_key_q <= rtcakl_pkg::BYTE_ZERO;
            pin_cfg_q <= rtcakl_pkg::BYTE_ZERO;
            sfr_rdata_q <= rtcakl_pkg::BYTE_ZERO;
            power_control_wr_q <= 1'b0;
            timekeep_wr_q <= 1'b0;
            prot_addr_q <= rtcakl_pkg::BYTE_ZERO;
            prot_wdata_q <= rtcakl_pkg::BYTE_ZERO;
        end else if (warm_reset) begin
            alarm_interval_q <= rtcakl_pkg::BYTE_ZERO;
            write_key_q <= rtcakl_pkg::BYTE_ZERO;
            pin_cfg_q <= rtcakl_pkg::BYTE_ZERO;
            sfr_rdata_q <= rtcakl_pkg::BYTE_ZERO;
            power_control_wr_q <= 1'b0;
            timekeep_wr_q <= 1'b0;
            prot_addr_q <= rtcakl_pkg::BYTE_ZERO;
            prot_wdata_q <= rtcakl_pkg::BYTE_ZERO;
        end else begin
            alarm_interval_q <= alarm_interval_d;
            write_key_q <= write_key_d;
            pin_cfg_q <= pin_cfg_d;
            sfr_rdata_q <= rdata_d;
            power_control_wr_q <= pwr_wr_d;
            timekeep_wr_q <= tk_wr_d;
            prot_addr_q <= prot_addr_d;
            prot_wdata_q <= prot_wdata_d;
        end
    end
    // ----------------------------------------------------------------
    // Compensation registers
    // ----------------------------------------------------------------
    // These ignore warm_reset so a watchdog trip does not cost the crystal trim.
    logic [7:0] comp_total_d;
    logic signed [8:0] comp_sum;
    always_comb begin
        nom_comp_d = nom_comp_q;
        temp_comp_d = temp_comp_q;
        if (sfr_wr && sfr_addr == rtcakl_pkg::ADDR_NOM_COMP) nom_comp_d = sfr_wdata; // [RL3]
        if (sfr_wr && sfr_addr == rtcakl_pkg::ADDR_TEMP_COMP) temp_comp_d = sfr_wdata; // [RL4]
        comp_sum = $signed({nom_comp_q[7], nom_comp_q}) + $signed({temp_comp_q[7], temp_comp_q});
        if (comp_sum > rtcakl_pkg::COMP_MAX) begin
            comp_total_d = rtcakl_pkg::COMP_MAX[7:0]; // [RL12]
        end else if (comp_sum < rtcakl_pkg::COMP_MIN) begin
            comp_total_d = rtcakl_pkg::COMP_MIN[7:0]; // [RL12]
        end else begin
            comp_total_d = comp_sum[7:0];
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nom_comp_q <= rtcakl_pkg::BYTE_ZERO; // [RL5]
            temp_comp_q <= rtcakl_pkg::BYTE_ZERO; // [RL5]
            comp_total_q <= rtcakl_pkg::BYTE_ZERO;
        end else begin
            nom_comp_q <= nom_comp_d;
            temp_comp_q <= temp_comp_d;
            comp_total_q <= comp_total_d;
        end
    end
    // ----------------------------------------------------------------
    // Interval alarm
    // ----------------------------------------------------------------
    logic [7:0] count_d, count_next;
    logic held_q, held_d, alarm_d, irq_d, hit;
    always_comb begin
        count_d = interval_count_q;
        held_d = held_q;
        irq_d = 1'b0;
        count_next = interval_count_q + 8'h01; // [RL2]
        hit = interval_enable && interval_tick && !held_q && (count_next == alarm_interval_q);
        if (!interval_enable) begin
            count_d = rtcakl_pkg::BYTE_ZERO;
            held_d = 1'b0;
        end else if (interval_tick && !held_q) begin
            count_d = hit ? rtcakl_pkg::BYTE_ZERO : count_next; // [RL1]
            held_d = hit && single_interval_stop; // [RL11]
            irq_d = hit; // [RL1]
        end
        // A new alarm in the clearing cycle wins so the event is never lost.
        alarm_d = hit || (alarm_flag_q && !alarm_flag_clear);
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            interval_count_q <= rtcakl_pkg::BYTE_ZERO;
            held_q <= 1'b0;
            alarm_flag_q <= 1'b0;
            rtc_irq_pulse_q <= 1'b0;
        end else if (warm_reset) begin
            interval_count_q <= rtcakl_pkg::BYTE_ZERO;
            held_q <= 1'b0;
            alarm_flag_q <= 1'b0;
            rtc_irq_pulse_q <= 1'b0;
        end else begin
            interval_count_q <= count_d;
            held_q <= held_d;
            alarm_flag_q <= alarm_d;
            rtc_irq_pulse_q <= irq_d;
        end
    end
    // ----------------------------------------------------------------
    // Calibration output and pin decode
    // ----------------------------------------------------------------
    logic [31:0] cal_cnt_q, cal_cnt_d, cal_limit;
    logic cal_tog_q, cal_tog_d, cal_en_d, cal_out_d, irq0_d, irq1_gpio_d, batt_d, irq1_in_d;
    rtcakl_pkg::rtcakl_cal_frequency_select_t cal_frequency_select;
    assign cal_frequency_select = rtcakl_pkg::rtcakl_cal_frequency_select_t'(pin_cfg_q[rtcakl_pkg::CAL_FREQUENCY_SELECT_HI:rtcakl_pkg::CAL_FREQUENCY_SELECT_LO]);
    always_comb begin
        unique case (cal_frequency_select)
            rtcakl_pkg::CAL_FREQUENCY_SELECT_1HZ: cal_limit = 32'(CAL_HALF_1HZ); // [RL7]
            rtcakl_pkg::CAL_FREQUENCY_SELECT_512HZ: cal_limit = 32'(CAL_HALF_512HZ); // [RL7]
            rtcakl_pkg::CAL_FREQUENCY_SELECT_500HZ: cal_limit = 32'(CAL_HALF_500HZ); // [RL7]
            rtcakl_pkg::CAL_FREQUENCY_SELECT_16KHZ: cal_limit = 32'(CAL_HALF_16KHZ); // [RL7]
        endcase
        cal_en_d = pin_cfg_q[rtcakl_pkg::CAL_EN_BIT];
        cal_cnt_d = cal_cnt_q + 32'h0000_0001;
        cal_tog_d = cal_tog_q;
        if (!cal_en_d) begin
            cal_cnt_d = 32'h0000_0000;
            cal_tog_d = 1'b0;
        end else if (cal_cnt_d >= cal_limit) begin
            cal_cnt_d = 32'h0000_0000;
            cal_tog_d = !cal_tog_q;
        end
        cal_out_d = cal_en_d && cal_tog_d; // [RL6]
        irq0_d = pin_cfg_q[rtcakl_pkg::IRQ0_BIT]; // [RL8]
        irq1_gpio_d = ~|pin_cfg_q[rtcakl_pkg::IRQ1_MID:rtcakl_pkg::IRQ1_LO]; // [RL8]
        batt_d = !pin_cfg_q[rtcakl_pkg::IRQ1_MID] && pin_cfg_q[rtcakl_pkg::IRQ1_LO]; // [RL8]
        irq1_in_d = pin_cfg_q[rtcakl_pkg::IRQ1_HI] && pin_cfg_q[rtcakl_pkg::IRQ1_MID]; // [RL8]
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cal_cnt_q <= 32'h0000_0000;
            cal_tog_q <= 1'b0;
            cal_out_q <= 1'b0;
            cal_out_enable_q <= 1'b0; // [RL15]
            ext_irq0_pin_enable_q <= 1'b0;
            ext_irq1_gpio_q <= 1'b1;
            battery_switch_control_q <= 1'b0;
            ext_irq1_input_en_q <= 1'b0;
        end else begin
            cal_cnt_q <= cal_cnt_d;
            cal_tog_q <= cal_tog_d;
            cal_out_q <= cal_out_d;
            cal_out_enable_q <= cal_en_d;
            ext_irq0_pin_enable_q <= irq0_d;
            ext_irq1_gpio_q <= irq1_gpio_d;
            battery_switch_control_q <= batt_d;
            ext_irq1_input_en_q <= irq1_in_d;
        end
    end
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    alarm_on_match_a: assert property (@(posedge clk) disable iff (!resetn) // [RL1]
        (!warm_reset && hit) |=> (alarm_flag_q && rtc_irq_pulse_q && interval_count_q == 8'h00))
        else $error("alarm not raised on interval match");
    repeat_or_hold_a: assert property (@(posedge clk) disable iff (!resetn) // [RL11]
        (!warm_reset && hit && single_interval_stop) ##1 (interval_enable && !warm_reset)
        |=> interval_count_q == 8'h00)
        else $error("interval counter not held after single alarm");
    power_key_a: assert property (@(posedge clk) disable iff (!resetn) // [RL9]
        power_control_wr_q |-> $past(write_key_q) == rtcakl_pkg::KEY_POWER)
        else $error("power control write accepted without key");
    timekeep_key_a: assert property (@(posedge clk) disable iff (!resetn) // [RL10]
        timekeep_wr_q |-> $past(write_key_q) == rtcakl_pkg::KEY_TIMEKEEP)
        else $error("counter write accepted without key");
    unkeyed_cfg_a: assert property (@(posedge clk) disable iff (!resetn) // [RL14]
        (sfr_wr && sfr_addr == rtcakl_pkg::ADDR_PIN_CFG && !warm_reset
        && write_key_q != rtcakl_pkg::KEY_TIMEKEEP) |=> $stable(pin_cfg_q))
        else $error("unkeyed pin config write changed register");
    comp_warm_a: assert property (@(posedge clk) disable iff (!resetn) // [RL5]
        (warm_reset && !sfr_wr) |=> ($stable(nom_comp_q) && $stable(temp_comp_q)))
        else $error("compensation lost on warm reset");
    comp_clamp_a: assert property (@(posedge clk) disable iff (!resetn) // [RL12]
        ($signed(comp_total_q) <= 8'sh7C) && ($signed(comp_total_q) >= -8'sh7C))
        else $error("compensation sum exceeds limit");
    cal_off_a: assert property (@(posedge clk) disable iff (!resetn) // [RL6]
        !pin_cfg_q[rtcakl_pkg::CAL_EN_BIT] ##1 !pin_cfg_q[rtcakl_pkg::CAL_EN_BIT] |-> !cal_out_q)
        else $error("calibration output active while disabled");
    pin_decode_a: assert property (@(posedge clk) disable iff (!resetn) // [RL8]
        $past(pin_cfg_q[rtcakl_pkg::IRQ1_MID:rtcakl_pkg::IRQ1_LO]) == 2'b01
        |-> (battery_switch_control_q && !ext_irq1_gpio_q))
        else $error("pin function decode wrong");
endmodule // rtcakl_core
`default_nettype wire

// ### test/rtc_alarm_calibration_keylock_bench.sv
// Self-checking bench for the alarm, compensation, calibration and key-lock core.
// Assumes the core is reached only through its byte-wide register strobes, tick, enable, stop, flag clear and reset inputs.
`timescale 1ns/100ps
`default_nettype none
module rtc_alarm_calibration_keylock_bench;
    // ----------------------------------------------------------------
    // Stimulus, observation and bookkeeping
    // ----------------------------------------------------------------
    // Short half periods keep each calibration rate measurable in a few dozen cycles.
    localparam int H1 = 8;
    localparam int H512 = 6;
    localparam int H500 = 5;
    localparam int H16K = 3;
    logic clk, resetn, warm_reset, sfr_wr, sfr_rd, interval_tick;
    logic interval_enable, single_interval_stop, alarm_flag_clear;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, interval_count_q, comp_total_q;
    logic [7:0] prot_addr_q, prot_wdata_q;
    logic alarm_flag_q, rtc_irq_pulse_q, cal_out_q, cal_out_enable_q, ext_irq0_pin_enable_q;
    logic ext_irq1_gpio_q, battery_switch_control_q, ext_irq1_input_en_q;
    logic power_control_wr_q, timekeep_wr_q, pw_seen, tk_seen, irq_seen;
    logic [2:0] f;
    int err_count, n_compared;
    int hx[4] = '{H1, H512, H500, H16K};
    logic [7:0] rmap[6] = '{8'hA6, 8'hC1, 8'hF6, 8'hF7, 8'hFF, 8'h10};
    rtcakl_core #(.CAL_HALF_1HZ(H1), .CAL_HALF_512HZ(H512), .CAL_HALF_500HZ(H500),
        .CAL_HALF_16KHZ(H16K)) u_dut (.clk(clk), .resetn(resetn), .warm_reset(warm_reset),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .interval_tick(interval_tick), .interval_enable(interval_enable),
        .single_interval_stop(single_interval_stop), .alarm_flag_clear(alarm_flag_clear),
        .sfr_rdata_q(sfr_rdata_q), .alarm_flag_q(alarm_flag_q),
        .rtc_irq_pulse_q(rtc_irq_pulse_q), .interval_count_q(interval_count_q),
        .comp_total_q(comp_total_q), .cal_out_q(cal_out_q), .cal_out_enable_q(cal_out_enable_q),
        .ext_irq0_pin_enable_q(ext_irq0_pin_enable_q), .ext_irq1_gpio_q(ext_irq1_gpio_q),
        .battery_switch_control_q(battery_switch_control_q),
        .ext_irq1_input_en_q(ext_irq1_input_en_q), .power_control_wr_q(power_control_wr_q),
        .timekeep_wr_q(timekeep_wr_q), .prot_addr_q(prot_addr_q), .prot_wdata_q(prot_wdata_q));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("mismatches %0d, comparisons %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Pulses from the accepted write are captured just after the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        #1;
        pw_seen = power_control_wr_q;
        tk_seen = timekeep_wr_q;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1;
        check(sfr_rdata_q, exp);
    endtask
    task automatic kwr(input logic [7:0] k, input logic [7:0] a, input logic [7:0] d);
        wr(8'hC1, k);
        wr(a, d);
    endtask
    task automatic tick();
        @(posedge clk);
        interval_tick <= 1'b1;
        @(posedge clk);
        interval_tick <= 1'b0;
        #1;
        irq_seen = rtc_irq_pulse_q;
    endtask
    // Waits for one toggle, then counts clocks to the next; a stuck output ends the run.
    task automatic half(input int exp);
        int n;
        logic last;
        for (int pass = 0; pass < 2; pass++) begin
            n = 0;
            last = cal_out_q;
            while (cal_out_q === last && n < 100) begin
                @(posedge clk);
                #1;
                n++;
            end
            if (n == 100) begin
                err_count++;
                summarize();
            end
        end
        check(8'(n), 8'(exp));
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {resetn, warm_reset, sfr_wr, sfr_rd, interval_tick} = 5'h00;
        {interval_enable, single_interval_stop, alarm_flag_clear} = 3'h0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        err_count = 0;
        n_compared = 0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        foreach (rmap[i]) rd(rmap[i], 8'h00);
        check({7'h00, cal_out_enable_q}, 8'h00);
        check({7'h00, ext_irq1_gpio_q}, 8'h01);
        wr(8'hF6, 8'h7F);
        wr(8'hF7, 8'h7F);
        rd(8'hF6, 8'h7F);
        rd(8'hF7, 8'h7F);
        check(comp_total_q, 8'h7C);
        wr(8'hF6, 8'h80);
        wr(8'hF7, 8'h80);
        rd(8'hF7, 8'h80);
        check(comp_total_q, 8'h84);
        wr(8'hF6, 8'h03);
        wr(8'hF7, 8'h05);
        wr(8'hA6, 8'h33);
        wr(8'hC1, 8'h11);
        rd(8'hA6, 8'h33);
        check(comp_total_q, 8'h08);
        @(posedge clk);
        warm_reset <= 1'b1;
        @(posedge clk);
        warm_reset <= 1'b0;
        rd(8'hF6, 8'h03);
        rd(8'hF7, 8'h05);
        rd(8'hA6, 8'h00);
        rd(8'hC1, 8'h00);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(8'hF6, 8'h00);
        rd(8'hF7, 8'h00);
        wr(8'hFF, 8'hEF);
        rd(8'hFF, 8'h00);
        kwr(8'hEA, 8'hFF, 8'hFF);
        rd(8'hFF, 8'hEF);
        kwr(8'hA7, 8'hFF, 8'h00);
        rd(8'hFF, 8'hEF);
        wr(8'hC5, 8'h5A);
        check({7'h00, pw_seen}, 8'h01);
        check(prot_wdata_q, 8'h5A);
        kwr(8'hEA, 8'hC5, 8'h11);
        check({7'h00, pw_seen}, 8'h00);
        wr(8'hA3, 8'h1E);
        check({7'h00, tk_seen}, 8'h01);
        check(prot_addr_q, 8'hA3);
        wr(8'hC1, 8'h00);
        wr(8'hA4, 8'h22);
        check({7'h00, tk_seen}, 8'h00);
        for (int v = 0; v < 8; v++) begin
            f = 3'(v);
            kwr(8'hEA, 8'hFF, {4'h0, f, f[0]});
            repeat (2) @(posedge clk);
            #1;
            check({7'h00, ext_irq0_pin_enable_q}, {7'h00, f[0]});
            check({7'h00, ext_irq1_gpio_q}, {7'h00, f[1:0] == 2'b00});
            check({7'h00, battery_switch_control_q}, {7'h00, f[1:0] == 2'b01});
            check({7'h00, ext_irq1_input_en_q}, {7'h00, f[2:1] == 2'b11});
        end
        for (int i = 0; i < 4; i++) begin
            kwr(8'hEA, 8'hFF, {1'b1, 2'(i), 5'h00});
            half(hx[i]);
            check({7'h00, cal_out_enable_q}, 8'h01);
        end
        kwr(8'hEA, 8'hFF, 8'h00);
        repeat (H1 + 2) @(posedge clk);
        #1;
        check({6'h00, cal_out_enable_q, cal_out_q}, 8'h00);
        @(posedge clk);
        interval_enable <= 1'b1;
        wr(8'hA6, 8'h03);
        for (int k = 1; k <= 6; k++) begin
            tick();
            check({7'h00, irq_seen}, {7'h00, k % 3 == 0});
            check(interval_count_q, 8'(k % 3));
        end
        check({7'h00, alarm_flag_q}, 8'h01);
        @(posedge clk);
        alarm_flag_clear <= 1'b1;
        @(posedge clk);
        alarm_flag_clear <= 1'b0;
        #1;
        check({7'h00, alarm_flag_q}, 8'h00);
        single_interval_stop <= 1'b1;
        for (int k = 1; k <= 6; k++) begin
            tick();
            check({7'h00, irq_seen}, {7'h00, k == 3});
        end
        check(interval_count_q, 8'h00);
        @(posedge clk);
        interval_enable <= 1'b0;
        single_interval_stop <= 1'b0;
        @(posedge clk);
        interval_enable <= 1'b1;
        wr(8'hA6, 8'hFF);
        repeat (254) tick();
        check(interval_count_q, 8'hFE);
        check({7'h00, irq_seen}, 8'h00);
        tick();
        check({7'h00, irq_seen}, 8'h01);
        summarize();
    end
endmodule // rtc_alarm_calibration_keylock_bench
`default_nettype wire
